/* rtl/spam_pkg.sv */
// constants for the spi address map, pin configuration and fifo logic
package spam_pkg;
    localparam int ADDR_W = 6;
    localparam int READ_BIT = 7;
    localparam int BURST_BIT = 6;
    localparam logic [5:0] ADDR_PIN2_CFG = 6'h00;
    localparam logic [5:0] ADDR_PIN1_CFG = 6'h01;
    localparam logic [5:0] ADDR_PIN0_CFG = 6'h02;
    localparam logic [5:0] ADDR_THRESHOLD_SETTING = 6'h03;
    localparam logic [5:0] ADDR_STROBE_FIRST = 6'h30;
    localparam logic [5:0] ADDR_STROBE_LAST = 6'h3D;
    localparam logic [5:0] ADDR_PART_NUMBER = 6'h30;
    localparam logic [5:0] ADDR_CHIP_VERSION = 6'h31;
    localparam logic [5:0] ADDR_FREQ_EST = 6'h32;
    localparam logic [5:0] ADDR_LINK_QUALITY = 6'h33;
    localparam logic [5:0] ADDR_SIGNAL_STRENGTH = 6'h34;
    localparam logic [5:0] ADDR_RADIO_STATE = 6'h35;
    localparam logic [5:0] ADDR_WAKE_HIGH = 6'h36;
    localparam logic [5:0] ADDR_WAKE_LOW = 6'h37;
    localparam logic [5:0] ADDR_PKT_STATUS = 6'h38;
    localparam logic [5:0] ADDR_SYNTH_CAL = 6'h39;
    localparam logic [5:0] ADDR_TX_COUNT = 6'h3A;
    localparam logic [5:0] ADDR_RX_COUNT = 6'h3B;
    localparam logic [5:0] ADDR_PA_TABLE = 6'h3E;
    localparam logic [5:0] ADDR_FIFO = 6'h3F;
    localparam int STROBE_N = 14;
    localparam int STB_SOFT_RESET = 0;
    localparam int STB_FLUSH_RX = 10;
    localparam int STB_FLUSH_TX = 11;
    localparam logic [7:0] PIN2_CFG_RESET = 8'h29;
    localparam logic [7:0] PIN1_CFG_RESET = 8'h2E;
    localparam logic [7:0] PIN0_CFG_RESET = 8'h3F;
    localparam logic [7:0] THRESHOLD_SETTING_RESET = 8'h07;
    localparam int INV_BIT = 6;
    localparam int TOP_BIT = 7;
    localparam int SEL_MSB = 5;
    localparam int THR_MSB = 3;
    localparam logic [5:0] SEL_CHIP_READY = 6'h29;
    localparam logic [5:0] SEL_TRISTATE = 6'h2E;
    localparam logic [5:0] SEL_XOSC_DIV = 6'h3F;
    localparam int XOSC_DIV = 192;
    localparam logic [6:0] XOSC_HALF_LAST = 7'(XOSC_DIV / 2 - 1);
    localparam int FIFO_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam logic [6:0] FIFO_FULL = 7'(FIFO_DEPTH);
    localparam logic [6:0] TX_THR_BASE = 7'h3D;
    localparam logic [6:0] THR_STEP = 7'h04;
    localparam int PA_ENTRIES = 8;
    localparam int PA_IDX_W = 3;
    typedef enum logic [2:0] {
        SPAM_IDLE = 3'b001,
        SPAM_HEADER = 3'b010,
        SPAM_DATA = 3'b100
    } spam_phase_t;
endpackage : spam_pkg

/* rtl/spam_spi_shift.sv */
// spi byte shifter, sampled on the system clock
`timescale 1ns/100ps
module spam_spi_shift
    import spam_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_mosi,
    input wire logic [7:0] tx_byte,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic [7:0] rx_byte,
    output logic byte_done,
    output logic frame_start,
    output logic frame_end,
    output logic tx_load
);
    logic sclk_q, csn_q, next_miso;
    logic [7:0] shift_in, shift_out, next_shift_in, next_shift_out, next_rx_byte;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic next_byte_done, next_start, next_end;
    logic rise, fall;

    always_comb
    begin
        rise = spi_sclk & ~sclk_q & ~spi_csn;
        fall = ~spi_sclk & sclk_q & ~spi_csn;
        next_start = ~spi_csn & csn_q;
        next_end = spi_csn & ~csn_q;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_bit_cnt = bit_cnt;
        next_rx_byte = rx_byte;
        next_byte_done = 1'b0;
        if (next_start)
            next_bit_cnt = 3'h0;
        if (tx_load)
            next_shift_out = tx_byte;
        else if (fall && bit_cnt != 3'h0)
            next_shift_out = {shift_out[6:0], 1'b0};
        if (rise)
        begin
            next_shift_in = {shift_in[6:0], spi_mosi};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
                next_rx_byte = {shift_in[6:0], spi_mosi};
                next_byte_done = 1'b1;
            end
        end
        next_miso = spi_csn ? 1'b0 : next_shift_out[7];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sclk_q <= 1'b0;
            csn_q <= 1'b1;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            bit_cnt <= 3'h0;
            rx_byte <= 8'h00;
            byte_done <= 1'b0;
            frame_start <= 1'b0;
            frame_end <= 1'b0;
            tx_load <= 1'b0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            sclk_q <= spi_sclk;
            csn_q <= spi_csn;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            bit_cnt <= next_bit_cnt;
            rx_byte <= next_rx_byte;
            byte_done <= next_byte_done;
            frame_start <= next_start;
            frame_end <= next_end;
            tx_load <= byte_done | frame_start;
            spi_miso <= next_miso;
            spi_miso_oe <= ~spi_csn;
        end
    end
endmodule : spam_spi_shift

/* rtl/spam_regs.sv */
// spi address map: strobes, status, pin configuration, pa table and fifos
`timescale 1ns/100ps
module spam_regs
    import spam_pkg::*;
#(
    parameter logic [7:0] PART_NUMBER = 8'h5A,
    parameter logic [7:0] CHIP_VERSION = 8'hA5
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic chip_ready_low,
    input wire logic [7:0] freq_offset_in,
    input wire logic [7:0] link_quality_in,
    input wire logic [7:0] signal_strength_in,
    input wire logic [7:0] radio_state_in,
    input wire logic [15:0] wake_timer_in,
    input wire logic [7:0] packet_status_in,
    input wire logic [7:0] synth_cal_in,
    input wire logic tx_pop,
    output logic [7:0] tx_data,
    input wire logic rx_push,
    input wire logic [7:0] rx_data,
    output logic [STROBE_N-1:0] strobe,
    output logic [2:0] general_out_pin,
    output logic [2:0] general_out_pin_oe,
    output logic pin_drive_strength,
    output logic temp_sensor_enable,
    output logic tx_thr_reached,
    output logic rx_thr_reached
);
    // pin select mux; unknown codes give low, before the invert bit
    function automatic logic pin_signal(input logic [5:0] sel, input logic rdy, input logic div);
        pin_signal = (sel == SEL_CHIP_READY) ? rdy : ((sel == SEL_XOSC_DIV) ? div : 1'b0);
    endfunction : pin_signal

    function automatic logic [6:0] tx_threshold(input logic [3:0] s);
        tx_threshold = TX_THR_BASE - 7'(THR_STEP * s);
    endfunction : tx_threshold

    function automatic logic [6:0] rx_threshold(input logic [3:0] s);
        rx_threshold = 7'(THR_STEP * (7'(s) + 7'h01));
    endfunction : rx_threshold

    logic [7:0] rx_byte, tx_byte;
    logic byte_done, frame_start, frame_end, tx_load;
    spam_phase_t phase, next_phase;
    logic [5:0] addr, next_addr;
    logic is_read, next_is_read, is_burst, next_is_burst;
    logic [7:0] pin2_cfg, pin1_cfg, pin0_cfg, threshold_setting;
    logic [7:0] next_pin2_cfg, next_pin1_cfg, next_pin0_cfg, next_threshold_setting;
    logic [7:0] pa_table [PA_ENTRIES];
    logic [7:0] next_pa_table [PA_ENTRIES];
    logic [PA_IDX_W-1:0] pa_idx, next_pa_idx;
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] tx_wr, tx_rd, rx_wr, rx_rd;
    logic [PTR_W-1:0] next_tx_wr, next_tx_rd, next_rx_wr, next_rx_rd;
    logic [CNT_W-1:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
    logic tx_under, rx_over, next_tx_under, next_rx_over;
    logic [7:0] next_tx_data;
    logic [STROBE_N-1:0] next_strobe;
    logic tx_push, rx_pop, do_tx_pop, do_rx_push, flush_tx, flush_rx, soft_reset;
    logic [6:0] div_cnt, next_div_cnt;
    logic xosc_div, next_xosc_div;
    logic [2:0] next_pin, next_pin_oe;
    logic [5:0] strobe_idx;

    spam_spi_shift u_shift (
        .clk(clk),
        .sys_rst(sys_rst),
        .spi_sclk(spi_sclk),
        .spi_csn(spi_csn),
        .spi_mosi(spi_mosi),
        .tx_byte(tx_byte),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .rx_byte(rx_byte),
        .byte_done(byte_done),
        .frame_start(frame_start),
        .frame_end(frame_end),
        .tx_load(tx_load)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read data for the next spi byte
    always_comb
    begin
        tx_byte = 8'h00;
        if (phase == SPAM_HEADER)
            tx_byte = {chip_ready_low, 7'h00};
        else if (phase == SPAM_DATA && is_read)
        begin
            if (is_burst && addr >= ADDR_STROBE_FIRST && addr <= ADDR_RX_COUNT)
            begin
                case (addr)
                    ADDR_PART_NUMBER: tx_byte = PART_NUMBER;
                    ADDR_CHIP_VERSION: tx_byte = CHIP_VERSION;
                    ADDR_FREQ_EST: tx_byte = freq_offset_in;
                    ADDR_LINK_QUALITY: tx_byte = link_quality_in;
                    ADDR_SIGNAL_STRENGTH: tx_byte = signal_strength_in;
                    ADDR_RADIO_STATE: tx_byte = radio_state_in;
                    ADDR_WAKE_HIGH: tx_byte = wake_timer_in[15:8];
                    ADDR_WAKE_LOW: tx_byte = wake_timer_in[7:0];
                    ADDR_PKT_STATUS: tx_byte = packet_status_in;
                    ADDR_SYNTH_CAL: tx_byte = synth_cal_in;
                    ADDR_TX_COUNT: tx_byte = {tx_under, tx_cnt};
                    ADDR_RX_COUNT: tx_byte = {rx_over, rx_cnt};
                    default: tx_byte = 8'h00;
                endcase
            end
            else
            begin
                case (addr)
                    ADDR_PIN2_CFG: tx_byte = {1'b0, pin2_cfg[INV_BIT:0]};
                    ADDR_PIN1_CFG: tx_byte = pin1_cfg;
                    ADDR_PIN0_CFG: tx_byte = pin0_cfg;
                    ADDR_THRESHOLD_SETTING: tx_byte = threshold_setting;
                    ADDR_PA_TABLE: tx_byte = pa_table[pa_idx];
                    ADDR_FIFO: tx_byte = rx_mem[rx_rd];
                    default: tx_byte = 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transaction decode and register writes
    always_comb
    begin
        next_phase = phase;
        next_addr = addr;
        next_is_read = is_read;
        next_is_burst = is_burst;
        next_pin2_cfg = pin2_cfg;
        next_pin1_cfg = pin1_cfg;
        next_pin0_cfg = pin0_cfg;
        next_threshold_setting = threshold_setting;
        next_pa_table = pa_table;
        next_pa_idx = pa_idx;
        next_strobe = '0;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        strobe_idx = rx_byte[SEL_MSB:0] - ADDR_STROBE_FIRST;
        if (frame_start)
            next_phase = SPAM_HEADER;
        else if (frame_end)
        begin
            next_phase = SPAM_IDLE;
            next_pa_idx = '0;
        end
        else if (byte_done && phase == SPAM_HEADER)
        begin
            next_phase = SPAM_DATA;
            next_addr = rx_byte[SEL_MSB:0];
            next_is_read = rx_byte[READ_BIT];
            next_is_burst = rx_byte[BURST_BIT];
            if (!rx_byte[BURST_BIT] && rx_byte[SEL_MSB:0] >= ADDR_STROBE_FIRST
                && rx_byte[SEL_MSB:0] <= ADDR_STROBE_LAST)
                next_strobe[strobe_idx[3:0]] = 1'b1;
        end
        else if (byte_done && phase == SPAM_DATA)
        begin
            if (!is_read)
            begin
                case (addr)
                    ADDR_PIN2_CFG: next_pin2_cfg = {1'b0, rx_byte[INV_BIT:0]};
                    ADDR_PIN1_CFG: next_pin1_cfg = rx_byte;
                    ADDR_PIN0_CFG: next_pin0_cfg = rx_byte;
                    ADDR_THRESHOLD_SETTING: next_threshold_setting = rx_byte;
                    ADDR_PA_TABLE: next_pa_table[pa_idx] = rx_byte;
                    ADDR_FIFO: tx_push = 1'b1;
                    default: ;
                endcase
            end
            else if (addr == ADDR_FIFO)
                rx_pop = rx_cnt != '0;
            if (addr == ADDR_PA_TABLE)
                next_pa_idx = pa_idx + 3'h1;
            if (is_burst && addr < ADDR_STROBE_FIRST)
                next_addr = addr + 6'h01;
        end
        soft_reset = next_strobe[STB_SOFT_RESET];
        if (soft_reset)
        begin
            next_pin2_cfg = PIN2_CFG_RESET;
            next_pin1_cfg = PIN1_CFG_RESET;
            next_pin0_cfg = PIN0_CFG_RESET;
            next_threshold_setting = THRESHOLD_SETTING_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fifo pointers, counts and error flags
    always_comb
    begin
        flush_tx = strobe[STB_FLUSH_TX] | strobe[STB_SOFT_RESET];
        flush_rx = strobe[STB_FLUSH_RX] | strobe[STB_SOFT_RESET];
        do_tx_pop = tx_pop && tx_cnt != '0;
        do_rx_push = rx_push && rx_cnt != FIFO_FULL;
        next_tx_data = do_tx_pop ? tx_mem[tx_rd] : tx_data;
        next_tx_wr = tx_wr + PTR_W'(tx_push && tx_cnt != FIFO_FULL);
        next_tx_rd = tx_rd + PTR_W'(do_tx_pop);
        next_tx_cnt = tx_cnt + CNT_W'(tx_push && tx_cnt != FIFO_FULL) - CNT_W'(do_tx_pop);
        next_rx_wr = rx_wr + PTR_W'(do_rx_push);
        next_rx_rd = rx_rd + PTR_W'(rx_pop);
        next_rx_cnt = rx_cnt + CNT_W'(do_rx_push) - CNT_W'(rx_pop);
        next_tx_under = tx_under;
        next_rx_over = rx_over;
        if (flush_tx)
        begin
            next_tx_wr = '0;
            next_tx_rd = '0;
            next_tx_cnt = '0;
            next_tx_under = 1'b0;
        end
        if (flush_rx)
        begin
            next_rx_wr = '0;
            next_rx_rd = '0;
            next_rx_cnt = '0;
            next_rx_over = 1'b0;
        end
        if (tx_pop && tx_cnt == '0)
            next_tx_under = 1'b1;
        if (rx_push && rx_cnt == FIFO_FULL)
            next_rx_over = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and clock divider
    always_comb
    begin
        next_div_cnt = div_cnt + 7'h01;
        next_xosc_div = xosc_div;
        if (div_cnt == XOSC_HALF_LAST)
        begin
            next_div_cnt = 7'h00;
            next_xosc_div = ~xosc_div;
        end
        next_pin[2] = pin_signal(pin2_cfg[SEL_MSB:0], chip_ready_low, xosc_div) ^ pin2_cfg[INV_BIT];
        next_pin[1] = pin_signal(pin1_cfg[SEL_MSB:0], chip_ready_low, xosc_div) ^ pin1_cfg[INV_BIT];
        next_pin[0] = pin_signal(pin0_cfg[SEL_MSB:0], chip_ready_low, xosc_div) ^ pin0_cfg[INV_BIT];
        next_pin_oe[2] = pin2_cfg[SEL_MSB:0] != SEL_TRISTATE;
        next_pin_oe[1] = pin1_cfg[SEL_MSB:0] != SEL_TRISTATE;
        next_pin_oe[0] = pin0_cfg[SEL_MSB:0] != SEL_TRISTATE;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phase <= SPAM_IDLE;
            addr <= '0;
            is_read <= 1'b0;
            is_burst <= 1'b0;
            pin2_cfg <= PIN2_CFG_RESET;
            pin1_cfg <= PIN1_CFG_RESET;
            pin0_cfg <= PIN0_CFG_RESET;
            threshold_setting <= THRESHOLD_SETTING_RESET;
            for (int i = 0; i < PA_ENTRIES; i++)
                pa_table[i] <= 8'h00;
            pa_idx <= '0;
            strobe <= '0;
            tx_wr <= '0;
            tx_rd <= '0;
            tx_cnt <= '0;
            rx_wr <= '0;
            rx_rd <= '0;
            rx_cnt <= '0;
            tx_under <= 1'b0;
            rx_over <= 1'b0;
            tx_data <= 8'h00;
            div_cnt <= 7'h00;
            xosc_div <= 1'b0;
            general_out_pin <= 3'h0;
            general_out_pin_oe <= 3'h0;
            pin_drive_strength <= 1'b0;
            temp_sensor_enable <= 1'b0;
            tx_thr_reached <= 1'b0;
            rx_thr_reached <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            addr <= next_addr;
            is_read <= next_is_read;
            is_burst <= next_is_burst;
            pin2_cfg <= next_pin2_cfg;
            pin1_cfg <= next_pin1_cfg;
            pin0_cfg <= next_pin0_cfg;
            threshold_setting <= next_threshold_setting;
            pa_table <= next_pa_table;
            pa_idx <= next_pa_idx;
            strobe <= next_strobe;
            if (tx_push && tx_cnt != FIFO_FULL)
                tx_mem[tx_wr] <= rx_byte;
            if (do_rx_push)
                rx_mem[rx_wr] <= rx_data;
            tx_wr <= next_tx_wr;
            tx_rd <= next_tx_rd;
            tx_cnt <= next_tx_cnt;
            rx_wr <= next_rx_wr;
            rx_rd <= next_rx_rd;
            rx_cnt <= next_rx_cnt;
            tx_under <= next_tx_under;
            rx_over <= next_rx_over;
            tx_data <= next_tx_data;
            div_cnt <= next_div_cnt;
            xosc_div <= next_xosc_div;
            general_out_pin <= next_pin;
            general_out_pin_oe <= next_pin_oe;
            pin_drive_strength <= pin1_cfg[TOP_BIT];
            temp_sensor_enable <= pin0_cfg[TOP_BIT];
            tx_thr_reached <= tx_cnt >= tx_threshold(threshold_setting[THR_MSB:0]);
            rx_thr_reached <= rx_cnt >= rx_threshold(threshold_setting[THR_MSB:0]);
        end
    end
endmodule : spam_regs

/* verif/spam_checker.sv */
// assertions on the register bank ports
`timescale 1ns/100ps
module spam_checker
    import spam_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_csn,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic chip_ready_low,
    input wire logic [STROBE_N-1:0] strobe,
    input wire logic [2:0] general_out_pin,
    input wire logic [2:0] general_out_pin_oe,
    input wire logic pin_drive_strength,
    input wire logic temp_sensor_enable,
    input wire logic tx_thr_reached,
    input wire logic rx_thr_reached
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // no frame seen since reset
    logic fresh;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            fresh <= 1'b1;
        else if (!spi_csn)
            fresh <= 1'b0;
    end
    sequence s_idle;
        spi_csn [*3];
    endsequence
    sequence s_release;
        $fell(sys_rst);
    endsequence
    sequence s_oe_reset;
        general_out_pin_oe == 3'b000 ##1 general_out_pin_oe == 3'b101;
    endsequence
    sequence s_flags_low;
        strobe == '0 && !pin_drive_strength && !temp_sensor_enable;
    endsequence
    sequence s_thr_low;
        !tx_thr_reached && !rx_thr_reached;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_strobe_pulse: assert property (strobe != '0 |-> $onehot(strobe) ##1 strobe == '0)
        else $error("strobe is not a one cycle single pulse");
    a_strobe_frame: assert property (strobe != '0 |-> !$past(spi_csn, 2))
        else $error("strobe outside a frame");
    a_miso_idle: assert property (s_idle |-> !spi_miso && !spi_miso_oe)
        else $error("miso active while deselected");
    a_oe_live: assert property (!spi_csn [*2] |-> spi_miso_oe)
        else $error("miso not driven in frame");
    a_pins_reset: assert property (s_release |-> s_oe_reset)
        else $error("pin enables wrong after reset");
    a_flags_reset: assert property (s_release |-> s_flags_low ##1 s_thr_low)
        else $error("flags wrong after reset");
    a_pin2_ready: assert property (fresh [*3] |-> general_out_pin[2] == $past(chip_ready_low))
        else $error("pin 2 not chip ready");
    a_pin1_undriven: assert property (fresh [*2] |-> !general_out_pin_oe[1])
        else $error("pin 1 driven after reset");
endmodule : spam_checker

/* verif/spam_host.sv */
// spi host model for the register bank
`timescale 1ns/100ps
module spam_host
(
    input wire logic clk,
    output logic spi_sclk,
    output logic spi_csn,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial
    begin
        spi_sclk = 1'b0;
        spi_csn = 1'b1;
        spi_mosi = 1'b0;
    end
    // mode 0 byte, msb first, each sclk phase four clocks
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--)
        begin
            spi_mosi = d[i];
            repeat (4) @(negedge clk);
            q[i] = spi_miso;
            spi_sclk = 1'b1;
            repeat (4) @(negedge clk);
            spi_sclk = 1'b0;
        end
    endtask : xfer
    task automatic start(input logic [7:0] hdr, output logic [7:0] q);
        spi_csn = 1'b0;
        xfer(hdr, q);
    endtask : start
    task automatic stop();
        repeat (4) @(negedge clk);
        spi_csn = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (4) @(negedge clk);
    endtask : stop
endmodule : spam_host

/* verif/testbench.sv */
// self-checking bench for the register bank
`timescale 1ns/100ps
module testbench
    import spam_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_sclk, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
    logic chip_ready_low = 1'b1;
    logic tx_pop = 1'b0;
    logic rx_push = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic [7:0] tx_data, r;
    logic [63:0] stat = 64'hA1B2C3D4E5F60718;
    logic [79:0] stv;
    logic [31:0] rst_v = 32'h292E3F07;
    logic [STROBE_N-1:0] strobe;
    logic [STROBE_N-1:0] seen = '0;
    logic [2:0] general_out_pin, general_out_pin_oe;
    logic pin_drive_strength, temp_sensor_enable, tx_thr_reached, rx_thr_reached;
    int n_errors = 0;
    int check_count = 0;
    assign stv = {8'h6B, 8'h94, stat};
    always #50 clk = ~clk;
    always @(posedge clk)
        seen <= seen | strobe;
    spam_host i_spam_host (.clk, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso);
    spam_regs #(.PART_NUMBER(8'h6B), .CHIP_VERSION(8'h94)) i_spam_regs (.clk, .sys_rst, .spi_sclk, .spi_csn,
        .spi_mosi, .spi_miso, .spi_miso_oe, .chip_ready_low, .freq_offset_in(stat[63:56]),
        .link_quality_in(stat[55:48]), .signal_strength_in(stat[47:40]), .radio_state_in(stat[39:32]),
        .wake_timer_in(stat[31:16]), .packet_status_in(stat[15:8]), .synth_cal_in(stat[7:0]), .tx_pop,
        .tx_data, .rx_push, .rx_data, .strobe, .general_out_pin, .general_out_pin_oe, .pin_drive_strength,
        .temp_sensor_enable, .tx_thr_reached, .rx_thr_reached);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] sv, input logic [15:0] ev);
        check_count++;
        if (sv !== ev)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, sv, ev);
        end
    endtask : check
    task automatic wr(input logic [7:0] hdr, input logic [7:0] d);
        i_spam_host.start(hdr, r);
        i_spam_host.xfer(d, r);
        i_spam_host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] hdr, output logic [7:0] d);
        i_spam_host.start(hdr, d);
        i_spam_host.xfer(8'h00, d);
        i_spam_host.stop();
    endtask : rd
    task automatic push(input int n, input logic [7:0] d);
        repeat (n)
        begin
            rx_push = 1'b1;
            rx_data = d;
            @(negedge clk);
            rx_push = 1'b0;
            @(negedge clk);
        end
    endtask : push
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (90000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        check(general_out_pin_oe, 3'b101);
        check(general_out_pin[2], 1'b1);
        r = 8'h00;
        repeat (192)
        begin
            @(negedge clk);
            r = r + 8'(general_out_pin[0]);
        end
        check(r, 8'h60);
        i_spam_host.start(8'hC0, r);
        check(r, 8'h80);
        for (int i = 0; i < 4; i++)
        begin
            i_spam_host.xfer(8'h00, r);
            check(r, rst_v[31-8*i -: 8]);
        end
        i_spam_host.stop();
        wr(8'h00, 8'hE9);
        rd(8'h80, r);
        check(r, 8'h69);
        check(general_out_pin[2], 1'b0);
        chip_ready_low = 1'b0;
        repeat (2) @(negedge clk);
        check(general_out_pin[2], 1'b1);
        chip_ready_low = 1'b1;
        wr(8'h01, 8'h80);
        check({pin_drive_strength, general_out_pin_oe[1], general_out_pin[1]}, 3'b110);
        wr(8'h01, 8'h40);
        check({pin_drive_strength, general_out_pin[1]}, 2'b01);
        wr(8'h02, 8'h80);
        check({temp_sensor_enable, general_out_pin[0]}, 2'b10);
        rd(8'h84, r);
        check(r, 8'h00);
        i_spam_host.start(8'h41, r);
        i_spam_host.xfer(8'h2E, r);
        i_spam_host.xfer(8'h00, r);
        i_spam_host.stop();
        check({general_out_pin_oe[1:0], temp_sensor_enable}, 3'b010);
        wr(8'h03, 8'h00);
        push(1, 8'hB0);
        push(2, 8'h11);
        check(rx_thr_reached, 1'b0);
        push(1, 8'h22);
        @(negedge clk);
        check(rx_thr_reached, 1'b1);
        wr(8'h03, 8'h0F);
        check({tx_thr_reached, rx_thr_reached}, 2'b00);
        wr(8'h3F, 8'h5C);
        check(tx_thr_reached, 1'b1);
        rd(8'hFA, r);
        check(r, 8'h01);
        tx_pop = 1'b1;
        @(negedge clk);
        check(tx_data, 8'h5C);
        @(negedge clk);
        tx_pop = 1'b0;
        rd(8'hFA, r);
        check(r, 8'h80);
        rd(8'hBF, r);
        check(r, 8'hB0);
        rd(8'hFB, r);
        check(r, 8'h03);
        push(62, 8'h33);
        rd(8'hFB, r);
        check(r, 8'hC0);
        check(rx_thr_reached, 1'b1);
        wr(8'h3E, 8'h3C);
        rd(8'hBE, r);
        check(r, 8'h3C);
        seen = '0;
        for (int i = 0; i < 10; i++)
        begin
            rd(8'hF0 + 8'(i), r);
            check(r, stv[79-8*i -: 8]);
        end
        wr(8'h7C, 8'h00);
        check(seen, 16'h0000);
        for (int k = 0; k < 28; k++)
        begin
            seen = '0;
            i_spam_host.start(k < 14 ? 8'h30 + 8'(k) : 8'hA2 + 8'(k), r);
            i_spam_host.stop();
            check(seen, 16'h0001 << (k % 14));
        end
        rd(8'hFB, r);
        check(r, 8'h00);
        print_verdict();
    end
endmodule : testbench
bind spam_regs spam_checker i_spam_checker (.clk, .sys_rst, .spi_csn, .spi_miso, .spi_miso_oe, .chip_ready_low,
    .strobe, .general_out_pin, .general_out_pin_oe, .pin_drive_strength, .temp_sensor_enable, .tx_thr_reached,
    .rx_thr_reached);
